/* inc/smpr_pkg.sv */
// constants for the supply monitor and pin reset block
package smpr_pkg;
  // bus geometry
  localparam int APB_AW = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // printed register indexes; byte address is four times the index
  localparam logic [APB_AW-1:0] IDX_MON_CTRL = 12'h0_0ff;
  localparam logic [APB_AW-1:0] IDX_RST_SRC = 12'h0_0ef;
  localparam logic [APB_AW-1:0] ADDR_MON_CTRL = 12'h3_fc;
  localparam logic [APB_AW-1:0] ADDR_RST_SRC = 12'h3_bc;
  // monitor control field positions
  localparam int BIT_MON_EN = 7;
  localparam int BIT_ABOVE_RST = 6;
  localparam int BIT_ABOVE_WARN = 5;
  localparam int BIT_WARN_IE = 3;
  // reset source field positions
  localparam int BIT_SEL_PWR = 1;
  localparam int BIT_PIN_FLAG = 0;
  // reset values
  localparam logic RST_MON_EN = 1'b1;
  localparam logic RST_WARN_IE = 1'b1;
  localparam logic RST_SEL = 1'b1;
  localparam logic RST_PWR_FLAG = 1'b1;
  localparam logic RST_PIN_FLAG = 1'b0;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_POR_DELAY_NS = 7000000;
  localparam int POR_DELAY_CYC = T_POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int T_MON_SETTLE_NS = 2000;
  localparam int MON_SETTLE_CYC =
    (T_MON_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 20;
  localparam int SETTLE_W = 12;
  // reset sequencer states
  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_RUN = 2'b01,
    ST_MON = 2'b10,
    ST_PIN = 2'b11
  } smpr_state_t;
endpackage : smpr_pkg

/* hw/smpr_supply_monitor_pin_reset.sv */
// supply monitor control, reset source flags and reset sequencing
//
// How it works
// - leaving a monitor reset skips the power-on delay entirely.
// - selecting an unsettled monitor may cause a system reset.
// - control bit 7 switches the monitor on or off, resets to one.
// - enabled monitor resets nothing unless also selected.
// - control bit 6 reads one while supply is above reset level.
// - control bit 5 reads one while supply is above warning level.
// - control bit 3 enables the early warning interrupt, resets one.
// - control bits 4 and 2:0 read zero, writes ignored.
// - low on the reset pin holds the device in reset.
// - pin reset works in suspend and sleep modes too.
// - leaving a pin reset sets the pin reset flag, bit 0.
// - select bit 1 writes select the monitor; reads show power flag.
// - supply falling below warning level may raise the interrupt.
// - only power-on and monitor resets set enable and select.
// - for monitor and power-on resets the pin is driven low.
`timescale 1ns/1ns
module smpr_supply_monitor_pin_reset #(
  parameter int POR_DELAY = smpr_pkg::POR_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [smpr_pkg::APB_AW-1:0] paddr,
  input wire logic [smpr_pkg::DATA_W-1:0] pwdata,
  output logic [smpr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  input wire logic supplyAboveReset,
  input wire logic supplyAboveWarn,
  input wire logic lowPowerSleep,
  output logic sysRstn,
  output logic earlyWarnIrq
);

  // pin, reset comparator, warning comparator
  logic [2:0] sync1_ff, sync2_ff;
  logic [2:0] nxt_sync1, nxt_sync2;
  logic pinHigh, aboveRst, aboveWarn;

  // two-stage capture; stage one feeds stage two only
  always_comb begin
    nxt_sync1 = {supplyAboveWarn, supplyAboveReset, rstPinIn};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // idle levels, so no false warning request follows reset
      sync1_ff <= '1;
      sync2_ff <= '1;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign pinHigh = sync2_ff[0];
  assign aboveRst = sync2_ff[1];
  assign aboveWarn = sync2_ff[2];

  // software-visible state
  logic monEn_ff, warnIe_ff, sel_ff, pwrFlag_ff, pinFlag_ff;
  logic nxt_monEn, nxt_warnIe, nxt_sel, nxt_pwrFlag, nxt_pinFlag;
  logic [smpr_pkg::SETTLE_W-1:0] settle_ff, nxt_settle;
  logic monReady, monTrip;

  // sequencer state
  smpr_pkg::smpr_state_t state_ff, nxt_state;
  logic [smpr_pkg::POR_CNT_W-1:0] porCnt_ff, nxt_porCnt;
  logic sysRstn_ff, nxt_sysRstn;
  logic pinOe_ff, nxt_pinOe;
  logic pinOut_ff;
  logic irq_ff, nxt_irq;
  logic [1:0] oeEcho_ff, nxt_oeEcho;
  logic pinEcho;

  // bus state
  logic [smpr_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic ready_ff, nxt_ready;
  logic err_ff, nxt_err;
  logic wrTake;

  // exact match on a register byte address
  function automatic logic hit(input logic [smpr_pkg::APB_AW-1:0] a,
                               input logic [smpr_pkg::APB_AW-1:0] r);
    hit = (a == r);
  endfunction : hit

  // monitor output counts as valid only after the turn-on time
  assign monReady = (settle_ff == smpr_pkg::SETTLE_W'(
    smpr_pkg::MON_SETTLE_CYC));
  // unsettled or low supply both trip; sleep masks the monitor
  assign monTrip = monEn_ff && sel_ff && !lowPowerSleep &&
                   !(monReady && aboveRst);

  // settle timer restarts whenever the monitor is off
  always_comb begin
    nxt_settle = settle_ff;
    if (!monEn_ff) begin
      nxt_settle = '0;
    end else if (!monReady) begin
      nxt_settle = settle_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // monitor runs through power-up, so it starts out settled
      settle_ff <= smpr_pkg::SETTLE_W'(smpr_pkg::MON_SETTLE_CYC);
    end else begin
      settle_ff <= nxt_settle;
    end
  end

  // own pin drive reaches the synchroniser two edges late; without
  // this mask every power-on or monitor reset would end in a false
  // pin reset and a wrong pin flag
  always_comb begin
    nxt_oeEcho = {oeEcho_ff[0], pinOe_ff};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      oeEcho_ff <= '1;
    end else begin
      oeEcho_ff <= nxt_oeEcho;
    end
  end

  assign pinEcho = |oeEcho_ff;

  // reset sequencer: power-on delay, monitor hold, pin hold
  always_comb begin
    nxt_state = state_ff;
    nxt_porCnt = porCnt_ff;
    case (state_ff)
      smpr_pkg::ST_POR: begin
        if (porCnt_ff >= smpr_pkg::POR_CNT_W'(POR_DELAY - 1)) begin
          nxt_state = smpr_pkg::ST_RUN;
        end else begin
          nxt_porCnt = porCnt_ff + 1'b1;
        end
      end
      smpr_pkg::ST_RUN: begin
        // monitor wins if both arrive together
        // our own drive echoing back is not a pin request
        if (monTrip) begin
          nxt_state = smpr_pkg::ST_MON;
        end else if (!pinHigh && !pinEcho) begin
          nxt_state = smpr_pkg::ST_PIN;
        end
      end
      smpr_pkg::ST_MON: begin
        // straight back to run, no power-on delay
        if (aboveRst) begin
          nxt_state = smpr_pkg::ST_RUN;
        end
      end
      smpr_pkg::ST_PIN: begin
        // a monitor trip during a pin hold takes over
        if (monTrip) begin
          nxt_state = smpr_pkg::ST_MON;
        end else if (pinHigh) begin
          nxt_state = smpr_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = smpr_pkg::ST_POR;
      end
    endcase
    // outputs follow the next state so they change with it
    nxt_sysRstn = (nxt_state == smpr_pkg::ST_RUN);
    // own pin driven low only for power-on and monitor resets
    nxt_pinOe = (nxt_state == smpr_pkg::ST_POR) ||
                (nxt_state == smpr_pkg::ST_MON);
    // level request, held while warning low and enabled
    nxt_irq = warnIe_ff && !aboveWarn;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= smpr_pkg::ST_POR;
      porCnt_ff <= '0;
      sysRstn_ff <= 1'b0;
      pinOe_ff <= 1'b1;
      pinOut_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      porCnt_ff <= nxt_porCnt;
      sysRstn_ff <= nxt_sysRstn;
      pinOe_ff <= nxt_pinOe;
      // pin is only ever pulled low; the enable does the work
      pinOut_ff <= 1'b0;
      irq_ff <= nxt_irq;
    end
  end

  // a write lands only at the edge that completes the access
  assign wrTake = psel && penable && ready_ff && pwrite;

  // register writes and reset-source flags
  always_comb begin
    nxt_monEn = monEn_ff;
    nxt_warnIe = warnIe_ff;
    nxt_sel = sel_ff;
    nxt_pwrFlag = pwrFlag_ff;
    nxt_pinFlag = pinFlag_ff;
    if (wrTake && hit(paddr, smpr_pkg::ADDR_MON_CTRL)) begin
      // unused bits simply not stored
      nxt_monEn = pwdata[smpr_pkg::BIT_MON_EN];
      nxt_warnIe = pwdata[smpr_pkg::BIT_WARN_IE];
    end
    if (wrTake && hit(paddr, smpr_pkg::ADDR_RST_SRC)) begin
      nxt_sel = pwdata[smpr_pkg::BIT_SEL_PWR];
    end
    // a monitor reset overrides any enable or select write in flight
    if (state_ff == smpr_pkg::ST_MON) begin
      nxt_monEn = 1'b1;
      nxt_sel = 1'b1;
    end
    // flags change only on leaving reset; pin reset keeps en/sel
    if (state_ff == smpr_pkg::ST_MON && nxt_state == smpr_pkg::ST_RUN) begin
      nxt_pwrFlag = 1'b1;
      nxt_pinFlag = 1'b0;
    end
    if (state_ff == smpr_pkg::ST_PIN && nxt_state == smpr_pkg::ST_RUN) begin
      nxt_pinFlag = 1'b1;
      nxt_pwrFlag = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      monEn_ff <= smpr_pkg::RST_MON_EN;
      warnIe_ff <= smpr_pkg::RST_WARN_IE;
      sel_ff <= smpr_pkg::RST_SEL;
      pwrFlag_ff <= smpr_pkg::RST_PWR_FLAG;
      pinFlag_ff <= smpr_pkg::RST_PIN_FLAG;
    end else begin
      monEn_ff <= nxt_monEn;
      warnIe_ff <= nxt_warnIe;
      sel_ff <= nxt_sel;
      pwrFlag_ff <= nxt_pwrFlag;
      pinFlag_ff <= nxt_pinFlag;
    end
  end

  // apb: data prepared in setup, one access cycle, no wait states
  always_comb begin
    nxt_ready = psel && !penable;
    nxt_rdata = '0;
    nxt_err = 1'b0;
    // status bits lag the pins by the two synchroniser stages
    if (psel && !penable) begin
      if (hit(paddr, smpr_pkg::ADDR_MON_CTRL)) begin
        nxt_rdata[smpr_pkg::BIT_MON_EN] = monEn_ff;
        nxt_rdata[smpr_pkg::BIT_ABOVE_RST] = aboveRst;
        nxt_rdata[smpr_pkg::BIT_ABOVE_WARN] = aboveWarn;
        nxt_rdata[smpr_pkg::BIT_WARN_IE] = warnIe_ff;
      end else if (hit(paddr, smpr_pkg::ADDR_RST_SRC)) begin
        nxt_rdata[smpr_pkg::BIT_SEL_PWR] = pwrFlag_ff;
        nxt_rdata[smpr_pkg::BIT_PIN_FLAG] = pinFlag_ff;
      end else begin
        nxt_err = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
    end
  end

  // every output comes straight from a register
  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;
  assign rstPinOut = pinOut_ff;
  assign rstPinOe = pinOe_ff;
  assign sysRstn = sysRstn_ff;
  assign earlyWarnIrq = irq_ff;

endmodule : smpr_supply_monitor_pin_reset

/* tb/smpr_props.sv */
// checker for the supply monitor and pin reset block
`timescale 1ns/1ns
module smpr_props #(
  parameter int POR_DELAY = 20
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic rstPinIn,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic supplyAboveReset,
  input wire logic supplyAboveWarn,
  input wire logic lowPowerSleep,
  input wire logic sysRstn,
  input wire logic earlyWarnIrq
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic porDone;
  logic rdCtl;
  // cycles since release; masks the power-on wait
  always_comb begin
    nxt_cnt = porDone ? cnt_ff : cnt_ff + 16'h0001;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign porDone = cnt_ff > 16'(POR_DELAY + 8);
  assign rdCtl = pready && !pwrite && paddr == smpr_pkg::ADDR_MON_CTRL;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_PIN_HOLD: assert property ((!rstPinIn)[*5] |-> !sysRstn)
    else $error("pin low did not hold reset");
  AST_SLEEP_PIN: assert property
    ((lowPowerSleep && !rstPinIn)[*5] |-> !sysRstn)
    else $error("pin reset lost in sleep");
  AST_PIN_LOW: assert property
    (rstPinOe |-> !rstPinOut && !sysRstn)
    else $error("driven pin not low");
  AST_MON_EXIT: assert property
    ((porDone && rstPinOe && supplyAboveReset) |-> ##[0:3] sysRstn)
    else $error("monitor reset release too slow");
  AST_IRQ_QUIET: assert property (supplyAboveWarn[*5] |-> !earlyWarnIrq)
    else $error("warning request without low supply");
  AST_RD_ZERO: assert property
    (rdCtl |-> (prdata & 32'hffff_ff17) == 32'h0000_0000)
    else $error("unused control bits not zero");
  AST_STAT_RST: assert property
    (($stable(supplyAboveReset))[*5] ##0 rdCtl |-> prdata[6] == supplyAboveReset)
    else $error("reset level status wrong");
  AST_STAT_WARN: assert property
    (($stable(supplyAboveWarn))[*5] ##0 rdCtl |-> prdata[5] == supplyAboveWarn)
    else $error("warning level status wrong");
  cover property (porDone && rstPinOe && !sysRstn);
  cover property (lowPowerSleep && !rstPinIn);
  cover property (earlyWarnIrq);
endmodule : smpr_props
bind smpr_supply_monitor_pin_reset smpr_props #(.POR_DELAY(POR_DELAY)) i_props (
  .core_clk(core_clk), .rstn(rstn), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .rstPinIn(rstPinIn),
  .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .sysRstn(sysRstn),
  .supplyAboveReset(supplyAboveReset), .supplyAboveWarn(supplyAboveWarn),
  .lowPowerSleep(lowPowerSleep), .earlyWarnIrq(earlyWarnIrq));

/* tb/smpr_partner.sv */
// reset pin wiring and supply comparators outside the block
`timescale 1ns/1ns
module smpr_partner (
  input wire logic pullLow,
  input wire logic supRst,
  input wire logic supWarn,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  output logic rstPinIn,
  output logic supplyAboveReset,
  output logic supplyAboveWarn
);
  // pull-up holds the pin high unless a party drives it low
  assign rstPinIn = !pullLow && (rstPinOe ? rstPinOut : 1'b1);
  assign supplyAboveReset = supRst;
  assign supplyAboveWarn = supWarn;
endmodule : smpr_partner

/* tb/smpr_supply_monitor_pin_reset_tb.sv */
// self-checking bench for the supply monitor and pin reset block
`timescale 1ns/1ns
module smpr_supply_monitor_pin_reset_tb;
  localparam int PD = 20;
  localparam logic [11:0] A_CTL = smpr_pkg::ADDR_MON_CTRL;
  localparam logic [11:0] A_SRC = smpr_pkg::ADDR_RST_SRC;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, lowPowerSleep = 1'b0, pullLow = 1'b0;
  logic supRst = 1'b1, supWarn = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, w;
  logic pready, pslverr, rstPinIn, rstPinOut, rstPinOe, sysRstn;
  logic supplyAboveReset, supplyAboveWarn, earlyWarnIrq;
  logic [32:0] expQ[$];
  int mismatches = 0, checksDone = 0, cyc = 0, seed = 31, n;
  smpr_supply_monitor_pin_reset #(.POR_DELAY(PD)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rstPinIn(rstPinIn),
    .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .sysRstn(sysRstn),
    .supplyAboveReset(supplyAboveReset), .supplyAboveWarn(supplyAboveWarn),
    .lowPowerSleep(lowPowerSleep), .earlyWarnIrq(earlyWarnIrq));
  smpr_partner i_far (
    .pullLow(pullLow), .supRst(supRst), .supWarn(supWarn),
    .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .rstPinIn(rstPinIn),
    .supplyAboveReset(supplyAboveReset), .supplyAboveWarn(supplyAboveWarn));
  initial forever #5 core_clk = ~core_clk;
  task automatic conclude();
    if (mismatches == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
    checksDone++;
    if (got !== ex) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask : tick
  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: the next call never re-raises psel in this step
    @(posedge core_clk);
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [32:0] ex);
    expQ.push_back(ex);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  // read results are matched against the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", expQ.pop_front(), {pslverr, prdata});
  end
  // hang guard, run needs about four hundred and twenty cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    tick(10);
    rstn <= 1'b1;
    while (sysRstn !== 1'b1) tick(1);
    tick(1);
    rd(A_CTL, 33'h0_0000_00e8);
    rd(A_SRC, 33'h0_0000_0002);
    rd(12'h004, 33'h1_0000_0000);
    xfer(1'b1, A_SRC, 32'h0000_0000);
    xfer(1'b1, A_CTL, 32'h0000_0000);
    rd(A_CTL, 33'h0_0000_0060);
    supRst <= 1'b0;
    tick(20);
    chk("sysRstn", 33'h1, sysRstn);
    rd(A_CTL, 33'h0_0000_0020);
    supRst <= 1'b1;
    xfer(1'b1, A_CTL, 32'h0000_0088);
    tick(250);
    xfer(1'b1, A_SRC, 32'h0000_00ff);
    tick(10);
    chk("sysRstn", 33'h1, sysRstn);
    // random writes, monitor kept on so no settle trip
    for (n = 0; n < 4; n++) begin
      w = $random(seed) | 32'h0000_0080;
      xfer(1'b1, A_CTL, w);
      rd(A_CTL, {25'h0, 8'he0 | (w[7:0] & 8'h08)});
    end
    xfer(1'b1, A_CTL, 32'h0000_0088);
    supWarn <= 1'b0;
    tick(8);
    chk("irq", 33'h1, earlyWarnIrq);
    rd(A_CTL, 33'h0_0000_00c8);
    supWarn <= 1'b1;
    lowPowerSleep <= 1'b1;
    pullLow <= 1'b1;
    tick(8 + ($unsigned($random(seed)) % 8));
    chk("sysRstn", 33'h0, sysRstn);
    pullLow <= 1'b0;
    lowPowerSleep <= 1'b0;
    while (sysRstn !== 1'b1) tick(1);
    tick(1);
    rd(A_SRC, 33'h0_0000_0001);
    supRst <= 1'b0;
    tick(10);
    chk("pin", 33'h0, rstPinIn);
    supRst <= 1'b1;
    n = 0;
    while (sysRstn !== 1'b1) begin
      tick(1);
      n++;
    end
    chk("fast", 33'h1, n < PD);
    tick(1);
    rd(A_SRC, 33'h0_0000_0002);
    rd(A_CTL, 33'h0_0000_00e8);
    tick(4);
    conclude();
  end
endmodule : smpr_supply_monitor_pin_reset_tb
